// >>> hw/awd_pkg.sv
// Constants shared by the window detector control block.
// Assumes an 8-bit register space with byte-wide registers.
package awd_pkg;
	// Register addresses in register space
	localparam logic [7:0] ADDR_POS_SEL = 8'hBB;
	localparam logic [7:0] ADDR_UP_LO   = 8'hC3;
	localparam logic [7:0] ADDR_UP_HI   = 8'hC4;
	localparam logic [7:0] ADDR_LO_LO   = 8'hC5;
	localparam logic [7:0] ADDR_LO_HI   = 8'hC6;
	// Reset values
	localparam logic [7:0] POS_SEL_RST  = 8'h00;
	localparam logic [7:0] UPPER_RST    = 8'hFF;
	localparam logic [7:0] LOWER_RST    = 8'h00;
	localparam logic [7:0] RDATA_RST    = 8'h00;
	localparam logic [7:0] RD_UNMAPPED  = 8'h00;
	// Positive input select field
	localparam int         POS_CODE_W   = 5;
	localparam logic [2:0] POS_UNUSED   = 3'h0;
	localparam logic [4:0] CODE_TEMP    = 5'h1E;
	localparam logic [4:0] CODE_SUPPLY  = 5'h1F;
	localparam int         NUM_PINS     = 21;
	// Limit word width
	localparam int         LIMIT_W      = 16;
endpackage : awd_pkg

// >>> hw/awd_window_cmp.sv
// Window comparator: flags a sample against two limit words.
// Assumes unsigned words of equal width, sampled by the caller.
`timescale 1ns/1ps
module awd_window_cmp #(
	parameter int W = 16
) (
	// Sample and limits
	input  wire logic [W-1:0] sample,
	input  wire logic [W-1:0] upper,
	input  wire logic [W-1:0] lower,
	// Result
	output logic              hit
);
	logic inside_mode;
	logic in_window;
	logic out_window;

	// Limit order alone picks inside or outside detection
	assign inside_mode = (lower > upper);
	assign in_window   = (sample > upper) && (sample < lower);
	assign out_window  = (sample > upper) || (sample < lower);
	assign hit         = inside_mode ? in_window : out_window;
endmodule : awd_window_cmp

// >>> hw/awd_top.sv
// Input selector and window detector registers for the converter.
// Assumes processor register strobes and converter results on CLK.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - A 5-bit code in bits 4..0 selects pins port1.0 up to port3.4, 0x1E temperature, 0x1F supply.
// - Bits 7..5 of the input select register read zero and ignore writes.
// - Every converter result is compared against both limit words without software help.
// - The window flag is not in the register space; it is driven on WIN_FLAG and serves as an interrupt request.
// - Inside or outside detection follows only from the order of the two limit words.
// - The upper limit word has separately writable bytes that reset to all ones.
// - The lower limit word has separately writable bytes that reset to all zeros.
module awd_top (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	// Register space access
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WE,
	input  wire logic        REG_RE,
	output logic      [7:0]  REG_RDATA,
	// Converter result path
	input  wire logic [15:0] CONV_DATA,
	input  wire logic        CONV_VALID,
	// Flag control and report
	input  wire logic        FLAG_CLR,
	output logic             WIN_FLAG,
	// Analog input mux control
	output logic      [4:0]  POS_CODE,
	output logic      [20:0] SEL_PORT_PIN,
	output logic             SEL_TEMP,
	output logic             SEL_SUPPLY
);
	logic [4:0]  pos_code_reg;
	logic [7:0]  up_lo_reg;
	logic [7:0]  up_hi_reg;
	logic [7:0]  lo_lo_reg;
	logic [7:0]  lo_hi_reg;
	logic        flag_reg;
	logic [7:0]  rdata_reg;
	logic [7:0]  rdata_next;
	logic [15:0] upper_word;
	logic [15:0] lower_word;
	logic        cmp_hit;
	logic        hit_event;
	logic [20:0] pin_sel_reg;
	logic        temp_sel_reg;
	logic        supply_sel_reg;

	////////////////////////////////////////////////////////////////////////////
	// Input select register, upper bits dropped on write
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pos_code_reg <= awd_pkg::POS_SEL_RST[4:0];
		end else if (REG_WE && (REG_ADDR == awd_pkg::ADDR_POS_SEL)) begin
			pos_code_reg <= REG_WDATA[4:0];
		end
	end

	// Upper limit bytes
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			up_lo_reg <= awd_pkg::UPPER_RST;
			up_hi_reg <= awd_pkg::UPPER_RST;
		end else if (REG_WE) begin
			if (REG_ADDR == awd_pkg::ADDR_UP_LO) begin
				up_lo_reg <= REG_WDATA;
			end
			if (REG_ADDR == awd_pkg::ADDR_UP_HI) begin
				up_hi_reg <= REG_WDATA;
			end
		end
	end

	// Lower limit bytes
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lo_lo_reg <= awd_pkg::LOWER_RST;
			lo_hi_reg <= awd_pkg::LOWER_RST;
		end else if (REG_WE) begin
			if (REG_ADDR == awd_pkg::ADDR_LO_LO) begin
				lo_lo_reg <= REG_WDATA;
			end
			if (REG_ADDR == awd_pkg::ADDR_LO_HI) begin
				lo_hi_reg <= REG_WDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux, unused select bits forced to zero
	always_comb begin
		rdata_next = awd_pkg::RD_UNMAPPED;
		case (REG_ADDR)
			awd_pkg::ADDR_POS_SEL: rdata_next = {awd_pkg::POS_UNUSED, pos_code_reg};
			awd_pkg::ADDR_UP_LO:   rdata_next = up_lo_reg;
			awd_pkg::ADDR_UP_HI:   rdata_next = up_hi_reg;
			awd_pkg::ADDR_LO_LO:   rdata_next = lo_lo_reg;
			awd_pkg::ADDR_LO_HI:   rdata_next = lo_hi_reg;
			default:               rdata_next = awd_pkg::RD_UNMAPPED;
		endcase
	end

	// Read data registered, held until next read
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_reg <= awd_pkg::RDATA_RST;
		end else if (REG_RE) begin
			rdata_reg <= rdata_next;
		end
	end

	assign REG_RDATA = rdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Input selection decode, reserved codes select nothing
	genvar gi;
	generate
		for (gi = 0; gi < awd_pkg::NUM_PINS; gi++) begin : g_pin
			always_ff @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					pin_sel_reg[gi] <= 1'b0;
				end else begin
					pin_sel_reg[gi] <= (REG_WE && (REG_ADDR == awd_pkg::ADDR_POS_SEL)) ?
						(REG_WDATA[4:0] == 5'(gi)) : (pos_code_reg == 5'(gi));
				end
			end
		end
	endgenerate

	// Internal sources
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			temp_sel_reg   <= 1'b0;
			supply_sel_reg <= 1'b0;
		end else if (REG_WE && (REG_ADDR == awd_pkg::ADDR_POS_SEL)) begin
			temp_sel_reg   <= (REG_WDATA[4:0] == awd_pkg::CODE_TEMP);
			supply_sel_reg <= (REG_WDATA[4:0] == awd_pkg::CODE_SUPPLY);
		end
	end

	assign POS_CODE     = pos_code_reg;
	assign SEL_PORT_PIN = pin_sel_reg;
	assign SEL_TEMP     = temp_sel_reg;
	assign SEL_SUPPLY   = supply_sel_reg;

	////////////////////////////////////////////////////////////////////////////
	// Window compare on every result
	assign upper_word = {up_hi_reg, up_lo_reg};
	assign lower_word = {lo_hi_reg, lo_lo_reg};

	awd_window_cmp #(
		.W (awd_pkg::LIMIT_W)
	) u_cmp (
		.sample (CONV_DATA),
		.upper  (upper_word),
		.lower  (lower_word),
		.hit    (cmp_hit)
	);

	assign hit_event = CONV_VALID && cmp_hit;

	// Sticky flag, a new hit wins over a clear
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flag_reg <= 1'b0;
		end else if (hit_event) begin
			flag_reg <= 1'b1;
		end else if (FLAG_CLR) begin
			flag_reg <= 1'b0;
		end
	end

	assign WIN_FLAG = flag_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_sel_upper_zero: assert property (
		(REG_RE && REG_ADDR == awd_pkg::ADDR_POS_SEL) |=> (REG_RDATA[7:5] == 3'h0))
		else $error("select register upper bits not zero");

	a_sel_write_code: assert property (
		(REG_WE && REG_ADDR == awd_pkg::ADDR_POS_SEL) |=> (POS_CODE == $past(REG_WDATA[4:0])))
		else $error("select code not written");

	a_pin_decode: assert property (
		(REG_WE && REG_ADDR == awd_pkg::ADDR_POS_SEL && REG_WDATA[4:0] < 5'h15)
		|=> (SEL_PORT_PIN == (21'h000001 << $past(REG_WDATA[4:0])) && !SEL_TEMP && !SEL_SUPPLY))
		else $error("pin decode wrong");

	a_internal_decode: assert property (
		(REG_WE && REG_ADDR == awd_pkg::ADDR_POS_SEL && REG_WDATA[4:0] >= 5'h1E)
		|=> (SEL_PORT_PIN == 21'h000000 && (SEL_TEMP != SEL_SUPPLY)
		&& (SEL_SUPPLY == $past(REG_WDATA[0]))))
		else $error("internal source decode wrong");

	a_upper_readback: assert property (
		(REG_WE && REG_ADDR == awd_pkg::ADDR_UP_HI) ##1 (REG_RE && REG_ADDR == awd_pkg::ADDR_UP_HI
		&& !REG_WE) |=> (REG_RDATA == $past(REG_WDATA, 2)))
		else $error("upper high byte readback wrong");

	a_lower_readback: assert property (
		(REG_WE && REG_ADDR == awd_pkg::ADDR_LO_LO) ##1 (REG_RE && REG_ADDR == awd_pkg::ADDR_LO_LO
		&& !REG_WE) |=> (REG_RDATA == $past(REG_WDATA, 2)))
		else $error("lower low byte readback wrong");

	a_inside_hit: assert property (
		(CONV_VALID && lower_word > upper_word && CONV_DATA > upper_word
		&& CONV_DATA < lower_word) |=> WIN_FLAG)
		else $error("inside hit not flagged");

	a_outside_hit: assert property (
		(CONV_VALID && lower_word <= upper_word && (CONV_DATA > upper_word
		|| CONV_DATA < lower_word)) |=> WIN_FLAG)
		else $error("outside hit not flagged");

	a_no_false_hit: assert property (
		(!WIN_FLAG && CONV_VALID && lower_word > upper_word && CONV_DATA >= lower_word)
		|=> !WIN_FLAG)
		else $error("flag set outside inside window");

	a_flag_sticky: assert property (
		(WIN_FLAG && !FLAG_CLR) |=> WIN_FLAG)
		else $error("flag dropped without clear");

	a_flag_clear: assert property (
		(FLAG_CLR && !hit_event) |=> !WIN_FLAG)
		else $error("flag not cleared");

	c_inside_mode: cover property (CONV_VALID && lower_word > upper_word && cmp_hit);
	c_outside_mode: cover property (CONV_VALID && lower_word <= upper_word && cmp_hit);
	c_set_over_clear: cover property (FLAG_CLR && hit_event);
	c_temp_select: cover property (SEL_TEMP);
endmodule : awd_top

// >>> tb/awd_conv_model.sv
// Converter result path model: one-cycle result pulses on request.
// Assumes the bench raises req for one cycle per wanted result.
`timescale 1ns/1ps
module awd_conv_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Request from the bench
	input  wire logic        req,
	input  wire logic [15:0] req_data,
	// Result path
	output logic      [15:0] conv_data,
	output logic             conv_valid
);
	// Pulse a result, scramble the data lines between results
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_valid <= 1'b0;
			conv_data  <= 16'hA5A5;
		end else begin
			conv_valid <= req;
			conv_data  <= req ? req_data : ~conv_data;
		end
	end
endmodule : awd_conv_model

// >>> tb/awd_top_tb_top.sv
// Self-checking bench for the input selector and window detector.
// Assumes register strobes and results are one-cycle pulses on CLK.
`timescale 1ns/1ps
module awd_top_tb_top;
	logic        CLK = 1'b0;
	logic        ARST_N = 1'b0;
	logic [7:0]  REG_ADDR = 8'h00;
	logic [7:0]  REG_WDATA = 8'h00;
	logic        REG_WE = 1'b0;
	logic        REG_RE = 1'b0;
	logic [7:0]  REG_RDATA;
	logic [15:0] CONV_DATA;
	logic        CONV_VALID;
	logic        FLAG_CLR = 1'b0;
	logic        WIN_FLAG;
	logic [4:0]  POS_CODE;
	logic [20:0] SEL_PORT_PIN;
	logic        SEL_TEMP;
	logic        SEL_SUPPLY;
	logic        req = 1'b0;
	logic [15:0] req_d = 16'h0000;
	int          fail_count = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [4:0]  c;
	logic [22:0] exp_sel;
	logic [4:0]  codes [5] = '{5'h00, 5'h14, 5'h15, 5'h1E, 5'h1F};
	logic [7:0]  addrs [6] = '{8'hBB, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
	logic [7:0]  rvals [6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

	awd_top u_dut (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .CONV_DATA(CONV_DATA),
		.CONV_VALID(CONV_VALID), .FLAG_CLR(FLAG_CLR), .WIN_FLAG(WIN_FLAG),
		.POS_CODE(POS_CODE), .SEL_PORT_PIN(SEL_PORT_PIN), .SEL_TEMP(SEL_TEMP),
		.SEL_SUPPLY(SEL_SUPPLY));
	awd_conv_model u_conv (.clk(CLK), .arst_n(ARST_N), .req(req), .req_data(req_d),
		.conv_data(CONV_DATA), .conv_valid(CONV_VALID));

	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare, verdict and access tasks
	task chk(input string what, input logic [22:0] seen, input logic [22:0] expv);
		check_count++;
		if (seen !== expv) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, expv, seen);
		end
	endtask : chk
	task results();
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR <= a; REG_WDATA <= d; REG_WE <= 1'b1;
		@(posedge CLK);
		REG_WE <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] expv);
		@(posedge CLK);
		REG_ADDR <= a; REG_RE <= 1'b1;
		@(posedge CLK);
		REG_RE <= 1'b0;
		@(negedge CLK);
		chk("rdata", REG_RDATA, expv);
	endtask : rd
	task lim(input logic [15:0] up, input logic [15:0] lo);
		wr(8'hC4, up[15:8]); wr(8'hC3, up[7:0]); wr(8'hC6, lo[15:8]); wr(8'hC5, lo[7:0]);
	endtask : lim
	task smp(input logic [15:0] d, input logic e);
		@(posedge CLK);
		req <= 1'b1; req_d <= d;
		@(posedge CLK);
		req <= 1'b0;
		@(posedge CLK);
		@(negedge CLK);
		chk("flag", WIN_FLAG, e);
		@(posedge CLK);
		FLAG_CLR <= 1'b1;
		@(posedge CLK);
		FLAG_CLR <= 1'b0;
		@(negedge CLK);
		chk("flag clear", WIN_FLAG, 1'b0);
	endtask : smp
	// Write then read the same byte on the very next cycle
	task wrrd(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK);
		REG_ADDR  <= a;
		REG_WDATA <= d;
		REG_WE    <= 1'b1;
		@(posedge CLK);
		REG_WE <= 1'b0;
		REG_RE <= 1'b1;
		@(posedge CLK);
		REG_RE <= 1'b0;
		@(negedge CLK);
		chk("write readback", REG_RDATA, d);
	endtask : wrrd

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge CLK);
		ARST_N <= 1'b1;
		for (int i = 0; i < 6; i++) rd(addrs[i], rvals[i]);
		chk("reset select", {SEL_SUPPLY, SEL_TEMP, SEL_PORT_PIN}, 23'h000001);
		chk("reset flag", WIN_FLAG, 1'b0);
		for (int i = 0; i < 5; i++) begin
			c = codes[i];
			wr(8'hBB, {3'h7, c});
			@(negedge CLK);
			exp_sel = (c < 5'h15) ? (23'h000001 << c) : (c == 5'h1E) ? 23'h200000 :
				(c == 5'h1F) ? 23'h400000 : 23'h000000;
			chk("select", {SEL_SUPPLY, SEL_TEMP, SEL_PORT_PIN}, exp_sel);
			chk("code", POS_CODE, c);
			rd(8'hBB, {3'h0, c});
		end
		smp(16'hFFFF, 1'b0);
		smp(16'h0000, 1'b0);
		lim(16'h0100, 16'h0050);
		rd(8'hC4, 8'h01);
		rd(8'hC5, 8'h50);
		wrrd(8'hC4, 8'h01);
		wrrd(8'hC5, 8'h50);
		smp(16'h0100, 1'b0);
		smp(16'h0101, 1'b1);
		smp(16'h004F, 1'b1);
		smp(16'h0050, 1'b0);
		lim(16'h0050, 16'h0100);
		smp(16'h0080, 1'b1);
		smp(16'h0050, 1'b0);
		smp(16'h0100, 1'b0);
		smp(16'h0051, 1'b1);
		// Hit and clear reach the flag in the same cycle: the hit wins
		@(posedge CLK);
		req   <= 1'b1;
		req_d <= 16'h0080;
		@(posedge CLK);
		req      <= 1'b0;
		FLAG_CLR <= 1'b1;
		@(posedge CLK);
		FLAG_CLR <= 1'b0;
		@(negedge CLK);
		chk("set over clear", WIN_FLAG, 1'b1);
		smp(16'h0050, 1'b1);
		results();
	end
endmodule : awd_top_tb_top
